// [common/pmsr_consts.svh]
// Register offsets, field positions and reset values of the power manager status bank
`ifndef PMSR_CONSTS_SVH
`define PMSR_CONSTS_SVH

`define PMSR_OFS_PPC 10'h004
`define PMSR_OFS_IEN_SET 10'h0C0
`define PMSR_OFS_IEN_DIS 10'h0C4
`define PMSR_OFS_IEN_STATE 10'h0C8
`define PMSR_OFS_PENDING 10'h0CC
`define PMSR_OFS_CLEAR 10'h0D0
`define PMSR_OFS_FLAGS 10'h0D4
`define PMSR_OFS_UNLOCK 10'h058
`define PMSR_OFS_RSTLOG 10'h180

`define PMSR_BIT_AE 31
`define PMSR_BIT_CLOCK_SWITCH_DONE 5
`define PMSR_BIT_CFD 0
`define PMSR_IRQ_BITS 32'h80000021

`define PMSR_PPC_RESET 9'h1FA
`define PMSR_FLAGS_RESET 32'h00000020
`define PMSR_UNLOCK_KEY 8'hAA

`define PMSR_RC_POR 0
`define PMSR_RC_BOD 1
`define PMSR_RC_EXT 2
`define PMSR_RC_WDT 3
`define PMSR_RC_SLEEP 6
`define PMSR_RC_OCD 8
`define PMSR_RC_JTAG 9
`define PMSR_RC_SPD 12
`define PMSR_RC_WIDTH 13

`define PMSR_CLOCK_SWITCH_DONE_CYCLES 4'h4

`endif

// [common/pmsr_pkg.sv]
// Types shared by the power manager status bank
package pmsr_pkg;
    typedef struct packed {
        logic [9:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } pmsr_bus_req_t;

    typedef struct packed {
        logic [5:0] req_clk_mask;
        logic ext_reset_test_mode;
        logic force_osc_output;
        logic reset_pin_pullup_off;
    } pmsr_ppc_t;

    typedef enum logic [0:0] {
        PMSR_LOCKED,
        PMSR_UNLOCKED
    } pmsr_lock_t;
endpackage : pmsr_pkg

// [hw/pmsr_bank.sv]
// Power manager status, interrupt, peripheral power control and reset cause registers
`timescale 1ns/1ps
`default_nettype none
`include "pmsr_consts.svh"

module pmsr_bank #(
    parameter int CLOCK_SWITCH_DONE_DELAY = 4
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [9:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic clock_fail_in,
    input wire logic [`PMSR_RC_WIDTH-1:0] reset_cause_in,
    output logic irq,
    output logic use_system_rc_oscillator,
    output logic reset_pin_pullup_off,
    output logic force_osc_output,
    output logic ext_reset_test_mode,
    output logic [5:0] request_clock_enable
);

    // ==========================================================
    // Reset release and input synchronisers
    logic [1:0] rst_sync;
    logic rst_n;
    logic cfd_s1, cfd_s2;
    logic [`PMSR_RC_WIDTH-1:0] rc_s1, rc_s2;

    // Release is synchronised so no register leaves reset on a partial edge
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // Clock failure detector and reset cause arrive from other logic
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfd_s1 <= 1'b0;
            cfd_s2 <= 1'b0;
            rc_s1 <= '0;
            rc_s2 <= '0;
        end else begin
            cfd_s1 <= clock_fail_in;
            cfd_s2 <= cfd_s1;
            rc_s1 <= reset_cause_in;
            rc_s2 <= rc_s1;
        end
    end

    // ==========================================================
    // Bus decode
    pmsr_pkg::pmsr_bus_req_t req;
    assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    logic wr_ppc, wr_set, wr_dis, wr_clr, wr_unlock, wr_clksel;
    assign wr_ppc = req.wr && (req.addr == `PMSR_OFS_PPC);
    assign wr_set = req.wr && (req.addr == `PMSR_OFS_IEN_SET);
    assign wr_dis = req.wr && (req.addr == `PMSR_OFS_IEN_DIS);
    assign wr_clr = req.wr && (req.addr == `PMSR_OFS_CLEAR);
    assign wr_unlock = req.wr && (req.addr == `PMSR_OFS_UNLOCK);
    // Clock select registers sit below the mask block; treated as offsets 0x000..0x00F other than the PPC offset 0x004
    assign wr_clksel = req.wr && (req.addr[9:4] == 6'h00) && (req.addr != `PMSR_OFS_PPC);

    // ==========================================================
    // Lock state: a locked-register write needs an unlock in the access just before it
    pmsr_pkg::pmsr_lock_t lock_st, next_lock_st;
    logic [9:0] unlock_addr, next_unlock_addr;
    logic access, lock_ok, lock_viol;

    assign access = req.wr || req.rd;
    // Peripheral power control is treated as the lock-protected register here
    assign lock_ok = (lock_st == pmsr_pkg::PMSR_UNLOCKED) && (unlock_addr == req.addr);
    assign lock_viol = wr_ppc && !lock_ok;

    // Any access consumes a pending unlock; a key write arms the next access
    always_comb begin
        next_lock_st = lock_st;
        next_unlock_addr = unlock_addr;
        if (access) begin
            next_lock_st = pmsr_pkg::PMSR_LOCKED;
        end
        if (wr_unlock && req.wdata[31:24] == `PMSR_UNLOCK_KEY) begin
            next_lock_st = pmsr_pkg::PMSR_UNLOCKED;
            next_unlock_addr = req.wdata[9:0];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_st <= pmsr_pkg::PMSR_LOCKED;
            unlock_addr <= 10'h000;
        end else begin
            lock_st <= next_lock_st;
            unlock_addr <= next_unlock_addr;
        end
    end

    // ==========================================================
    // Peripheral power control
    pmsr_pkg::pmsr_ppc_t ppc, next_ppc;

    always_comb begin
        next_ppc = ppc;
        if (wr_ppc && lock_ok) begin
            next_ppc = pmsr_pkg::pmsr_ppc_t'(req.wdata[8:0]);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ppc <= pmsr_pkg::pmsr_ppc_t'(`PMSR_PPC_RESET);
        end else begin
            ppc <= next_ppc;
        end
    end

    assign reset_pin_pullup_off = ppc.reset_pin_pullup_off;
    assign force_osc_output = ppc.force_osc_output;
    assign ext_reset_test_mode = ppc.ext_reset_test_mode;
    assign request_clock_enable = ppc.req_clk_mask;

    // ==========================================================
    // Status flags
    logic ae, next_ae, cfd, next_cfd, clock_switch_done, next_clock_switch_done;
    logic [3:0] ck_cnt, next_ck_cnt;
    logic [31:0] flags, flags_q;

    // Access error stays until reset; clock ready waits a fixed settle time
    always_comb begin
        next_ae = ae || lock_viol;
        next_cfd = cfd || cfd_s2;
        next_ck_cnt = ck_cnt;
        next_clock_switch_done = clock_switch_done;
        if (wr_clksel) begin
            next_ck_cnt = 4'(CLOCK_SWITCH_DONE_DELAY);
            next_clock_switch_done = 1'b0;
        end else if (ck_cnt != 4'h0) begin
            next_ck_cnt = ck_cnt - 4'h1;
            if (ck_cnt == 4'h1) begin
                next_clock_switch_done = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ae <= 1'b0;
            cfd <= 1'b0;
            clock_switch_done <= 1'b1;
            ck_cnt <= 4'h0;
        end else begin
            ae <= next_ae;
            cfd <= next_cfd;
            clock_switch_done <= next_clock_switch_done;
            ck_cnt <= next_ck_cnt;
        end
    end

    // Main clock moves to the system RC oscillator once failure is seen
    assign use_system_rc_oscillator = cfd;

    always_comb begin
        flags = 32'h00000000;
        flags[`PMSR_BIT_AE] = ae;
        flags[`PMSR_BIT_CLOCK_SWITCH_DONE] = clock_switch_done;
        flags[`PMSR_BIT_CFD] = cfd;
    end

    // ==========================================================
    // Interrupt enable state and pending bits
    logic [31:0] ien, next_ien, pend, next_pend, rise;

    assign rise = flags & ~flags_q & `PMSR_IRQ_BITS;

    // Edge set wins over a simultaneous clear so no event is lost
    always_comb begin
        next_ien = ien;
        if (wr_set) begin
            next_ien = next_ien | (req.wdata & `PMSR_IRQ_BITS);
        end
        if (wr_dis) begin
            next_ien = next_ien & ~req.wdata;
        end
        next_pend = pend;
        if (wr_clr) begin
            next_pend = next_pend & ~req.wdata;
        end
        next_pend = next_pend | rise;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ien <= 32'h00000000;
            pend <= 32'h00000000;
            flags_q <= `PMSR_FLAGS_RESET;
        end else begin
            ien <= next_ien;
            pend <= next_pend;
            flags_q <= flags;
        end
    end

    assign irq = |(pend & ien);

    // ==========================================================
    // Reset cause log: captured once after release, read-only afterwards
    logic [`PMSR_RC_WIDTH-1:0] rc_log, next_rc_log;
    logic [2:0] rc_wait, next_rc_wait;

    // Wait for the synchroniser to fill before the straps are captured
    always_comb begin
        next_rc_log = rc_log;
        next_rc_wait = rc_wait;
        if (rc_wait != 3'h3) begin
            next_rc_wait = rc_wait + 3'h1;
            if (rc_wait == 3'h2) begin
                next_rc_log = rc_s2;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rc_log <= '0;
            rc_wait <= 3'h0;
        end else begin
            rc_log <= next_rc_log;
            rc_wait <= next_rc_wait;
        end
    end

    // ==========================================================
    // Read port: data one cycle after the strobe, zero elsewhere
    logic [31:0] next_rdata;

    always_comb begin
        next_rdata = 32'h00000000;
        if (req.rd) begin
            unique case (req.addr)
                `PMSR_OFS_PPC: next_rdata = {23'h0, ppc};
                `PMSR_OFS_IEN_STATE: next_rdata = ien;
                `PMSR_OFS_PENDING: next_rdata = pend;
                `PMSR_OFS_FLAGS: next_rdata = flags;
                `PMSR_OFS_RSTLOG: next_rdata = {19'h0, rc_log};
                default: next_rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 32'h00000000;
        end else begin
            rdata <= next_rdata;
        end
    end

    // ==========================================================
    // Checks
    sequence s_set_write;
        wr_set && wdata[`PMSR_BIT_CFD] && !wr_dis;
    endsequence

    a_enable_set_bit: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_set_write |=> ien[`PMSR_BIT_CFD]) else $error("enable set failed");
    a_enable_dis_bit: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_dis && wdata[`PMSR_BIT_CFD] |=> !ien[`PMSR_BIT_CFD]) else $error("disable failed");
    a_pending_edge_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !pend[`PMSR_BIT_CLOCK_SWITCH_DONE] ##1 pend[`PMSR_BIT_CLOCK_SWITCH_DONE] |->
        $past(clock_switch_done) && !$past(clock_switch_done, 2)) else $error("pending without edge");
    a_pending_rise_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(cfd) |=> pend[`PMSR_BIT_CFD]) else $error("edge did not set pending");
    a_clear_pending: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_clr && wdata[`PMSR_BIT_AE] && !rise[`PMSR_BIT_AE] |=> !pend[`PMSR_BIT_AE])
        else $error("clear failed");
    a_clear_zero_keeps: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_clr && wdata == 32'h0 |=> pend == ($past(pend) | $past(rise)))
        else $error("zero clear changed pending");
    a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (pend & ~`PMSR_IRQ_BITS) == 32'h0 && (ien & ~`PMSR_IRQ_BITS) == 32'h0)
        else $error("reserved bit set");
    a_access_error: assert property (@(posedge ref_clk) disable iff (!rst_n)
        lock_viol && !ae |=> ae ##1 pend[`PMSR_BIT_AE]) else $error("access error missed");
    a_clock_ready_wait: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_clksel ##1 !wr_clksel [*4] |=> clock_switch_done) else $error("clock ready late");
    a_clock_ready_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_clksel |=> !clock_switch_done) else $error("clock ready not dropped");
    a_failover_rc: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cfd_s2 |=> use_system_rc_oscillator && flags[`PMSR_BIT_CFD])
        else $error("failover missing");
    a_ppc_locked_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
        lock_viol |=> ppc == $past(ppc)) else $error("locked write took effect");
    a_ppc_outputs: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_ppc && lock_ok |=> request_clock_enable == $past(wdata[8:3]) &&
        reset_pin_pullup_off == $past(wdata[0])) else $error("control outputs wrong");
    a_irq_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_set && ((wdata & pend & `PMSR_IRQ_BITS) != 32'h0) |=> irq)
        else $error("irq level wrong");
    a_rst_log_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rc_wait == 3'h3 ##1 1'b1 |-> $stable(rc_log)) else $error("reset log changed");

endmodule : pmsr_bank
`default_nettype wire

// [sim/tb.sv]
// Self-checking bench for the power manager status, interrupt and reset cause bank
`timescale 1ns/1ps
`default_nettype none
`include "pmsr_consts.svh"

module tb;
    localparam int CKD = 4;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [9:0] addr = 10'h000;
    logic [31:0] wdata = 32'h00000000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic clock_fail_in = 1'b0;
    logic [`PMSR_RC_WIDTH-1:0] reset_cause_in = 13'h0001;
    logic [31:0] rdata;
    logic irq;
    logic use_system_rc_oscillator;
    logic reset_pin_pullup_off;
    logic force_osc_output;
    logic ext_reset_test_mode;
    logic [5:0] request_clock_enable;
    logic rd_q = 1'b0;
    logic [31:0] exp_q[$];
    logic [8:0] v;
    int failures = 0;
    int cmp_count = 0;
    int causes[8] = '{0, 1, 2, 3, 6, 8, 9, 12};

    pmsr_bank #(.CLOCK_SWITCH_DONE_DELAY(CKD)) uut (
        .ref_clk(ref_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .clock_fail_in(clock_fail_in), .reset_cause_in(reset_cause_in),
        .irq(irq), .use_system_rc_oscillator(use_system_rc_oscillator),
        .reset_pin_pullup_off(reset_pin_pullup_off), .force_osc_output(force_osc_output),
        .ext_reset_test_mode(ext_reset_test_mode),
        .request_clock_enable(request_clock_enable)
    );

    // ========================================
    // Clock, comparison and bus tasks
    // 25 MHz clock
    always #20 ref_clk = ~ref_clk;

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : idle

    // Single-cycle write strobe, released at the edge that takes it
    task automatic bus_wr(input logic [9:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask : bus_wr

    // The expectation is queued now; the monitor judges it a cycle later
    task automatic bus_rd(input logic [9:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        rd <= 1'b1;
        addr <= a;
        exp_q.push_back(exp);
        @(posedge ref_clk);
        rd <= 1'b0;
    endtask : bus_rd

    // Read data stand only in the cycle after the strobe, so sample there
    always @(posedge ref_clk) begin
        if (rd_q) begin
            chk("rdata", exp_q.pop_front(), rdata);
        end
        rd_q <= rd;
    end

    // Cause is held steady across the release so the log captures it cleanly
    task automatic do_reset(input int c);
        @(posedge ref_clk);
        nrst <= 1'b0;
        clock_fail_in <= 1'b0;
        reset_cause_in <= 13'h0001 << c;
        repeat (16) @(posedge ref_clk);
        nrst <= 1'b1;
        idle(10);
    endtask : do_reset

    task automatic chk_ppc(input logic [8:0] p);
        chk("pullup_off", {31'h0, p[0]}, {31'h0, reset_pin_pullup_off});
        chk("force_osc", {31'h0, p[1]}, {31'h0, force_osc_output});
        chk("test_mode", {31'h0, p[2]}, {31'h0, ext_reset_test_mode});
        chk("req_clk", {26'h0, p[8:3]}, {26'h0, request_clock_enable});
        bus_rd(`PMSR_OFS_PPC, {23'h0, p});
    endtask : chk_ppc

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude

    // ========================================
    // Main sequence
    initial begin
        void'($urandom(32'h8028));
        do_reset(0);
        // Reset values and reserved places
        chk_ppc(9'h1FA);
        bus_rd(`PMSR_OFS_FLAGS, 32'h00000020);
        bus_rd(`PMSR_OFS_PENDING, 32'h00000000);
        bus_rd(`PMSR_OFS_IEN_STATE, 32'h00000000);
        bus_rd(`PMSR_OFS_RSTLOG, 32'h00000001);
        bus_rd(`PMSR_OFS_CLEAR, 32'h00000000);
        bus_rd(10'h3F0, 32'h00000000);
        chk("rc_osc", 32'h0, {31'h0, use_system_rc_oscillator});
        // Enable set and disable; only the three sources exist
        bus_wr(`PMSR_OFS_IEN_SET, 32'hFFFFFFFF);
        bus_rd(`PMSR_OFS_IEN_STATE, 32'h80000021);
        bus_wr(`PMSR_OFS_IEN_DIS, 32'h00000001);
        bus_rd(`PMSR_OFS_IEN_STATE, 32'h80000020);
        // Locked write without unlock is dropped and flags an access error
        bus_wr(`PMSR_OFS_PPC, 32'h00000000);
        idle(1);
        chk_ppc(9'h1FA);
        bus_rd(`PMSR_OFS_FLAGS, 32'h80000020);
        bus_rd(`PMSR_OFS_PENDING, 32'h80000000);
        idle(1);
        chk("irq_on", 32'h1, {31'h0, irq});
        // Zeros to the clear port change nothing; a one clears, a steady flag stays quiet
        bus_wr(`PMSR_OFS_CLEAR, 32'h00000000);
        bus_rd(`PMSR_OFS_PENDING, 32'h80000000);
        bus_wr(`PMSR_OFS_CLEAR, 32'h80000000);
        idle(4);
        bus_rd(`PMSR_OFS_PENDING, 32'h00000000);
        idle(1);
        chk("irq_off", 32'h0, {31'h0, irq});
        // Unlocked write with a random value
        v = 9'($urandom);
        bus_wr(`PMSR_OFS_UNLOCK, {`PMSR_UNLOCK_KEY, 14'h0, `PMSR_OFS_PPC});
        bus_wr(`PMSR_OFS_PPC, {23'h7FFFFF, v});
        idle(1);
        chk_ppc(v);
        // Clock select write drops the ready flag until it takes effect
        bus_wr(10'h000, 32'h00000000);
        idle(1);
        bus_rd(`PMSR_OFS_FLAGS, 32'h80000000);
        idle(CKD + 6);
        bus_rd(`PMSR_OFS_FLAGS, 32'h80000020);
        bus_rd(`PMSR_OFS_PENDING, 32'h00000020);
        idle(1);
        chk("irq_clock_switch_done", 32'h1, {31'h0, irq});
        // Clock failure: flag, pending and oscillator switch
        @(posedge ref_clk);
        clock_fail_in <= 1'b1;
        idle(8);
        chk("rc_osc", 32'h1, {31'h0, use_system_rc_oscillator});
        bus_rd(`PMSR_OFS_FLAGS, 32'h80000021);
        bus_rd(`PMSR_OFS_PENDING, 32'h00000021);
        // Failure source is still disabled, so only the ready source drives the line
        bus_wr(`PMSR_OFS_CLEAR, 32'h00000020);
        idle(1);
        chk("irq_masked", 32'h0, {31'h0, irq});
        bus_wr(`PMSR_OFS_IEN_SET, 32'h00000001);
        idle(1);
        chk("irq_unmask", 32'h1, {31'h0, irq});
        bus_wr(`PMSR_OFS_CLEAR, 32'h00000001);
        idle(4);
        bus_rd(`PMSR_OFS_PENDING, 32'h00000000);
        idle(1);
        chk("irq_clr", 32'h0, {31'h0, irq});
        // Every reset source lands on its own bit
        foreach (causes[i]) begin
            do_reset(causes[i]);
            bus_rd(`PMSR_OFS_RSTLOG, 32'h00000001 << causes[i]);
            chk("rc_osc_rst", 32'h0, {31'h0, use_system_rc_oscillator});
        end
        chk_ppc(9'h1FA);
        idle(4);
        conclude();
    end

    // Hang guard, well beyond the few hundred cycles the sequence needs
    initial begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        conclude();
    end
endmodule : tb
`default_nettype wire
